// ---- common/reclose_pkg.sv ----
// Package for the automatic reclose sequencer: register map, field layout, timing and states.
// Assumes a 20 MHz clock and a 32-bit APB register bus with one aligned word per register.
package reclose_pkg;

  // Clock and time base; all programmable times count in units of one millisecond.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_TIME_NS  = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Widths.
  localparam int TIME_W  = 16;
  localparam int SHOT_W  = 4;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int NUM_DT  = 4;

  // Largest number of reclose attempts a program may hold.
  localparam logic [SHOT_W-1:0] MAX_SHOTS = 4'h9;
  localparam logic [SHOT_W-1:0] LAST_DT   = 4'h3;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] CTRL_ADDR      = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR  = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR  = 8'h0C;
  localparam logic [ADDR_W-1:0] LIMITS_ADDR    = 8'h10;
  localparam logic [ADDR_W-1:0] RESTRAINT_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] CLOSE_MAX_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] BLOCK_T_ADDR   = 8'h1C;
  localparam logic [ADDR_W-1:0] ACTION_T_ADDR  = 8'h20;
  localparam logic [ADDR_W-1:0] DEAD_GND_ADDR  = 8'h40;
  localparam logic [ADDR_W-1:0] DEAD_PH_ADDR   = 8'h50;

  // Field positions.
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_AUX_CB  = 1;
  localparam int LIM_GND_LSB  = 0;
  localparam int LIM_PH_LSB   = 4;
  localparam int IRQ_CLOSE    = 0;
  localparam int IRQ_SUCCESS  = 1;
  localparam int IRQ_BLOCK    = 2;
  localparam int IRQ_W        = 3;

  // Reset values.
  localparam logic [1:0]        CTRL_RST   = 2'h0;
  localparam logic [7:0]        LIMITS_RST = 8'h11;
  localparam logic [TIME_W-1:0] TIME_RST   = 16'h0064;

  // Sequencer states, Gray coded along ready, action, open wait, dead, restraint.
  typedef enum logic [2:0] {
    ST_READY   = 3'h0,
    ST_ACTION  = 3'h1,
    ST_OPEN    = 3'h3,
    ST_DEAD    = 3'h2,
    ST_RESTR   = 3'h6,
    ST_BLOCKED = 3'h7
  } seq_state_t;

endpackage : reclose_pkg

// ---- logic/ms_timer.sv ----
// One programmable down-counting timer stepped by the shared millisecond tick.
// Assumes tick is a one-cycle pulse in the clk domain and that ce freezes it.
`timescale 1ns/10ps
module ms_timer
  import reclose_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              tick,
  input  wire logic              load,
  input  wire logic              stop,
  input  wire logic [TIME_W-1:0] value,
  output logic                   running,
  output logic                   expired
);

  logic [TIME_W-1:0] cnt_reg;

  // Load restarts the count; the last tick ends it with a one-cycle expiry pulse.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      expired <= 1'b0;
      if (load)
      begin
        cnt_reg <= value;
        running <= 1'b1;
      end
      else if (stop)
        running <= 1'b0;
      else if (running && tick)
      begin
        if (cnt_reg <= TIME_W'(1))
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg - TIME_W'(1);
      end
    end
  end

endmodule : ms_timer

// ---- logic/reclose_seq.sv ----
// Three-pole multi-shot automatic reclose sequencer with APB registers and one interrupt.
// Assumes protection pickups, trips and breaker contacts are synchronous to clk.
//
// Summary of operation
// (R1) Ground program only when at most one phase, with or without ground, picked up.
// (R2) Phase program in all other cases, two or more phases, ground or not.
// (R3) Each program can also be started by its own external start input.
// (R4) Selection accumulates pickups only, ignores dropouts, until the breaker opens.
// (R5) Attempt limit set separately per program, at most nine.
// (R6) Four dead times per program; fifth and later attempts reuse the fourth.
// (R7) After trip and breaker opening run dead time, then close and start restraint.
// (R8) New fault during restraint with no shot left enters dynamic blocking.
// (R9) Breaker open from auxiliary contact if configured, else general pickup dropout.
// (R10) Restraint expiry without new fault returns to ready.
// (R11) Unsuccessful attempt restarts cycle with next dead time until limit reached.
// (R12) Final trip after last allowed attempt enters dynamic blocking, no close.
// (R13) Close command limited to a maximum time, withdrawn at once on new trip.
// (R14) Restraint is extended while the close command still runs.
// (R15) Starter pickup during restraint extends the restraint time.
// (R16) Starter trip within action time starts program; later trip during pickup blocks.
// (R17) Blocking timer restarts on expiry while a blocking condition persists.
// (R18) Shot counter counts close commands, indexes dead times, clears at ready.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module reclose_seq
  import reclose_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        phase_pickup,
  input  wire logic              ground_pickup,
  input  wire logic              general_pickup,
  input  wire logic              starter_trip,
  input  wire logic              any_trip,
  input  wire logic              ext_start_ground,
  input  wire logic              ext_start_phase,
  input  wire logic              cb_aux_closed,
  output logic                   close_cmd,
  output logic                   dyn_block,
  output logic                   ground_program,
  output logic                   irq
);

  seq_state_t state_reg;
  logic [1:0]              ctrl_reg;
  logic [7:0]              limits_reg;
  logic [TIME_W-1:0]       restraint_reg, close_max_reg, block_t_reg, action_t_reg;
  logic [TIME_W-1:0]       dead_reg [2][NUM_DT];
  logic [IRQ_W-1:0]        irq_stat_reg, irq_mask_reg;
  logic [SHOT_W-1:0]       shot_reg;
  logic [2:0]              phase_seen_reg;
  logic                    ext_phase_reg, action_over_reg;
  logic [15:0]             tick_cnt_reg;
  logic                    tick;

  // Bus decode.
  logic       acc, wr, rd, mapped, dead_hit;
  logic       dead_prog;
  logic [1:0] dead_sel;
  assign pready    = ce;
  assign acc       = psel && penable && ce;
  assign wr        = acc && pwrite && mapped;
  assign rd        = acc && !pwrite && mapped;
  assign dead_hit  = (paddr[ADDR_W-1:5] == DEAD_GND_ADDR[ADDR_W-1:5]) && (paddr[1:0] == 2'h0);
  assign dead_prog = paddr[4];
  assign dead_sel  = paddr[3:2];
  assign mapped    = dead_hit || paddr inside {CTRL_ADDR, STATUS_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR,
                     LIMITS_ADDR, RESTRAINT_ADDR, CLOSE_MAX_ADDR, BLOCK_T_ADDR, ACTION_T_ADDR};
  assign pslverr   = acc && !mapped;

  // Millisecond tick prescaler shared by all timers.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt_reg <= '0;
    else if (ce)
      tick_cnt_reg <= (tick_cnt_reg == 16'(TICK_DIV - 1)) ? '0 : tick_cnt_reg + 16'h0001;
  end
  assign tick = (tick_cnt_reg == 16'(TICK_DIV - 1));

  // Derived conditions.
  logic [SHOT_W-1:0] limit_gnd, limit_ph, limit_sel, dead_idx;
  logic [1:0]        phase_count;
  logic              cb_open, starter_pu, pickup_any, enable, ground_sel;
  assign enable      = ctrl_reg[CTRL_ENABLE];
  assign limit_gnd   = (limits_reg[LIM_GND_LSB +: SHOT_W] > MAX_SHOTS) ? MAX_SHOTS
                       : limits_reg[LIM_GND_LSB +: SHOT_W];                                // R5
  assign limit_ph    = (limits_reg[LIM_PH_LSB +: SHOT_W] > MAX_SHOTS) ? MAX_SHOTS
                       : limits_reg[LIM_PH_LSB +: SHOT_W];                                 // R5
  assign limit_sel   = ground_program ? limit_gnd : limit_ph;
  assign dead_idx    = (shot_reg > LAST_DT) ? LAST_DT : shot_reg;                           // R6
  assign phase_count = 2'(phase_seen_reg[0]) + 2'(phase_seen_reg[1]) + 2'(phase_seen_reg[2]);
  assign ground_sel  = (phase_count <= 2'h1) && !ext_phase_reg;                            // R1 R2
  assign cb_open     = ctrl_reg[CTRL_AUX_CB] ? !cb_aux_closed : !general_pickup;            // R9
  assign pickup_any  = (|phase_pickup) || ground_pickup;
  assign starter_pu  = pickup_any || ext_start_ground || ext_start_phase;

  // Timers.
  logic act_ld, act_run, act_exp, dead_ld, dead_exp, res_ld, res_run, res_exp;
  logic cls_run, cls_exp, blk_ld, blk_exp, any_stop;
  logic [TIME_W-1:0] dead_val;
  assign dead_val = dead_reg[ground_sel ? 0 : 1][dead_idx[1:0]];                           // R6
  assign any_stop = !enable;

  ms_timer u_action (.clk(clk), .arst_n(arst_n), .ce(ce), .tick(tick), .load(act_ld), .stop(any_stop),
                     .value(action_t_reg), .running(act_run), .expired(act_exp));
  ms_timer u_dead   (.clk(clk), .arst_n(arst_n), .ce(ce), .tick(tick), .load(dead_ld), .stop(any_stop),
                     .value(dead_val), .running(), .expired(dead_exp));
  ms_timer u_restr  (.clk(clk), .arst_n(arst_n), .ce(ce), .tick(tick), .load(res_ld), .stop(any_stop),
                     .value(restraint_reg), .running(res_run), .expired(res_exp));
  ms_timer u_close  (.clk(clk), .arst_n(arst_n), .ce(ce), .tick(tick), .load(dead_exp), .stop(any_stop),
                     .value(close_max_reg), .running(cls_run), .expired(cls_exp));
  ms_timer u_block  (.clk(clk), .arst_n(arst_n), .ce(ce), .tick(tick), .load(blk_ld), .stop(any_stop),
                     .value(block_t_reg), .running(), .expired(blk_exp));

  // Sequencer transitions.
  seq_state_t state_next;
  logic       block_cond, restr_done, final_fault, next_fault;
  assign block_cond  = general_pickup || any_trip;
  assign restr_done  = (res_exp && !cls_run) || (state_reg == ST_RESTR && !res_run && !res_ld && cls_exp);
  assign next_fault  = starter_trip && (shot_reg < limit_sel);
  assign final_fault = starter_trip && (shot_reg >= limit_sel);

  always_comb
  begin
    state_next = state_reg;
    act_ld     = 1'b0;
    dead_ld    = 1'b0;
    res_ld     = 1'b0;
    blk_ld     = 1'b0;
    unique case (state_reg)
      ST_READY:
        if (enable && (ext_start_ground || ext_start_phase))
          state_next = ST_OPEN;                                                            // R3
        else if (enable && pickup_any)
        begin
          state_next = ST_ACTION;
          act_ld     = 1'b1;
        end
      ST_ACTION:
        if (starter_trip && (act_run || act_ld))
          state_next = ST_OPEN;                                                            // R16
        else if (starter_trip && general_pickup)
          state_next = ST_BLOCKED;                                                         // R16
        else if (!general_pickup && !pickup_any)
          state_next = ST_READY;
      ST_OPEN:
        if (cb_open)
        begin
          state_next = ST_DEAD;                                                            // R9
          dead_ld    = 1'b1;
        end
      ST_DEAD:
        if (dead_exp)
        begin
          state_next = ST_RESTR;                                                           // R7
          res_ld     = 1'b1;
        end
      ST_RESTR:
        if (next_fault)
          state_next = ST_OPEN;                                                            // R11
        else if (final_fault)
          state_next = ST_BLOCKED;                                                         // R8 R12
        else if (starter_pu)
          res_ld = 1'b1;                                                                   // R15
        else if (res_exp && cls_run)
          res_ld = 1'b0;                                                                   // R14
        else if (restr_done)
          state_next = ST_READY;                                                           // R10
      ST_BLOCKED:
        if (blk_exp && !block_cond)
          state_next = ST_READY;                                                           // R17
        else if (blk_exp)
          blk_ld = 1'b1;                                                                   // R17
      default:
        state_next = ST_READY;
    endcase
    if (state_next == ST_BLOCKED && state_reg != ST_BLOCKED)
      blk_ld = 1'b1;
    if (!enable)
      state_next = ST_READY;
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ST_READY;
    else if (ce)
      state_reg <= state_next;
  end

  // Shot counter: one step per close command, cleared whenever the sequence is ready.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      shot_reg <= '0;
    else if (ce)
    begin
      if (state_next == ST_READY)
        shot_reg <= '0;                                                                    // R18
      else if (state_reg == ST_DEAD && dead_exp)
        shot_reg <= shot_reg + SHOT_W'(1);                                                 // R18
    end
  end

  // Program selection accumulates only elements seen picked up until the breaker opens.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_seen_reg <= '0;
      ext_phase_reg  <= 1'b0;
      ground_program <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg == ST_READY && state_next == ST_READY)
      begin
        phase_seen_reg <= '0;
        ext_phase_reg  <= 1'b0;
      end
      else if (state_reg inside {ST_READY, ST_ACTION, ST_OPEN} && !(state_reg == ST_OPEN && cb_open))
      begin
        phase_seen_reg <= phase_seen_reg | phase_pickup;                                   // R4
        ext_phase_reg  <= ext_phase_reg | ext_start_phase;                                 // R3
      end
      if (state_reg == ST_OPEN && cb_open)
        ground_program <= ground_sel;                                                      // R1 R2
    end
  end

  // Close command: raised as the dead time ends, dropped at its time limit or on any trip.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      close_cmd <= 1'b0;
    else if (ce)
    begin
      if (state_reg == ST_DEAD && dead_exp)
        close_cmd <= 1'b1;                                                                 // R7
      else if (any_trip || cls_exp || !enable)
        close_cmd <= 1'b0;                                                                 // R13
    end
  end

  // Dynamic blocking flag follows the blocked state.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dyn_block <= 1'b0;
    else if (ce)
      dyn_block <= (state_next == ST_BLOCKED);
  end

  // Configuration registers written over APB.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg      <= CTRL_RST;
      limits_reg    <= LIMITS_RST;
      restraint_reg <= TIME_RST;
      close_max_reg <= TIME_RST;
      block_t_reg   <= TIME_RST;
      action_t_reg  <= TIME_RST;
      irq_mask_reg  <= '0;
      for (int p = 0; p < 2; p++)
        for (int i = 0; i < NUM_DT; i++)
          dead_reg[p][i] <= TIME_RST;
    end
    else if (wr)
    begin
      if (dead_hit)
        dead_reg[dead_prog][dead_sel] <= pwdata[TIME_W-1:0];                               // R6
      else
        unique case (paddr)
          CTRL_ADDR:      ctrl_reg      <= pwdata[1:0];
          IRQ_MASK_ADDR:  irq_mask_reg  <= pwdata[IRQ_W-1:0];
          LIMITS_ADDR:    limits_reg    <= pwdata[7:0];                                    // R5
          RESTRAINT_ADDR: restraint_reg <= pwdata[TIME_W-1:0];
          CLOSE_MAX_ADDR: close_max_reg <= pwdata[TIME_W-1:0];                             // R13
          BLOCK_T_ADDR:   block_t_reg   <= pwdata[TIME_W-1:0];
          ACTION_T_ADDR:  action_t_reg  <= pwdata[TIME_W-1:0];
          default:        ;
        endcase
    end
  end

  // Sticky events; an interrupt status read clears the bits it returned, but an event in the same cycle survives.
  logic [IRQ_W-1:0] irq_evt;
  assign irq_evt[IRQ_CLOSE]   = ce && state_reg == ST_DEAD && dead_exp;
  assign irq_evt[IRQ_SUCCESS] = ce && state_reg == ST_RESTR && state_next == ST_READY;
  assign irq_evt[IRQ_BLOCK]   = ce && state_reg != ST_BLOCKED && state_next == ST_BLOCKED;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= ((rd && paddr == IRQ_STAT_ADDR) ? (irq_stat_reg & ~prdata[IRQ_W-1:0]) : irq_stat_reg) | irq_evt;
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data is registered in the setup cycle so that it stands through the access phase.
  logic [DATA_W-1:0] rdata;
  always_comb
  begin
    rdata = '0;
    if (dead_hit)
      rdata[TIME_W-1:0] = dead_reg[dead_prog][dead_sel];
    else
      unique case (paddr)
        CTRL_ADDR:      rdata[1:0] = ctrl_reg;
        STATUS_ADDR:    rdata[11:0] = {dyn_block, close_cmd, ground_program, shot_reg, 2'h0, state_reg};
        IRQ_STAT_ADDR:  rdata[IRQ_W-1:0] = irq_stat_reg;
        IRQ_MASK_ADDR:  rdata[IRQ_W-1:0] = irq_mask_reg;
        LIMITS_ADDR:    rdata[7:0] = limits_reg;
        RESTRAINT_ADDR: rdata[TIME_W-1:0] = restraint_reg;
        CLOSE_MAX_ADDR: rdata[TIME_W-1:0] = close_max_reg;
        BLOCK_T_ADDR:   rdata[TIME_W-1:0] = block_t_reg;
        ACTION_T_ADDR:  rdata[TIME_W-1:0] = action_t_reg;
        default:        rdata = '0;
      endcase
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= '0;
    else if (ce && psel && !penable && !pwrite && mapped)
      prdata <= rdata;
  end

  // Checks on the sequencer.
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_dead_end;
    ce && state_reg == ST_DEAD && dead_exp;
  endsequence
  sequence s_closing;
    close_cmd && state_reg == ST_RESTR;
  endsequence

  property p_close_after_dead;
    s_dead_end |=> s_closing;
  endproperty
  a_close_after_dead: assert property (p_close_after_dead) else $error("No close after dead time."); // R7

  property p_shot_step;
    s_dead_end |=> shot_reg == $past(shot_reg) + SHOT_W'(1);
  endproperty
  a_shot_step: assert property (p_shot_step) else $error("Shot counter did not step."); // R18

  property p_ready_clear;
    state_reg == ST_READY |-> shot_reg == '0;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("Shot counter set while ready."); // R18

  property p_close_withdraw;
    ce && close_cmd && any_trip && !(state_reg == ST_DEAD && dead_exp) |=> !close_cmd;
  endproperty
  a_close_withdraw: assert property (p_close_withdraw) else $error("Close kept through a trip."); // R13

  property p_final_block;
    ce && enable && state_reg == ST_RESTR && final_fault |=> dyn_block && !close_cmd [*2];
  endproperty
  a_final_block: assert property (p_final_block) else $error("Final trip did not block."); // R12

  property p_next_cycle;
    ce && enable && state_reg == ST_RESTR && next_fault |=> state_reg == ST_OPEN;
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("Next shot did not start."); // R11

  property p_ground_sel;
    $rose(ground_program) |-> phase_count <= 2'h1 && !ext_phase_reg;
  endproperty
  a_ground_sel: assert property (p_ground_sel) else $error("Ground program with two phases."); // R1

  property p_dead_index;
    dead_ld && shot_reg >= LAST_DT |-> dead_val == dead_reg[ground_sel ? 0 : 1][NUM_DT-1];
  endproperty
  a_dead_index: assert property (p_dead_index) else $error("Dead time index past the fourth."); // R6

  property p_block_release;
    ce && enable && state_reg == ST_BLOCKED && blk_exp && !block_cond |=> !dyn_block;
  endproperty
  a_block_release: assert property (p_block_release) else $error("Blocking not released."); // R17

  property p_late_trip;
    ce && enable && state_reg == ST_ACTION && starter_trip && !act_run && general_pickup |=> dyn_block;
  endproperty
  a_late_trip: assert property (p_late_trip) else $error("Late starter trip did not block."); // R16

endmodule : reclose_seq

// ---- tb/breaker_model.sv ----
// Behavioural circuit breaker facing the reclose sequencer.
// Assumes trip and close are levels synchronous to clk.
`timescale 1ns/10ps
module breaker_model
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic trip,
  input  wire logic close_cmd,
  output logic      cb_aux_closed
);
  // Contacts follow the last command one cycle later; a trip wins over a close.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cb_aux_closed <= 1'b1;
    else if (trip)
      cb_aux_closed <= 1'b0;
    else if (close_cmd)
      cb_aux_closed <= 1'b1;
  end
endmodule : breaker_model

// ---- tb/testbench.sv ----
// Self-checking bench for the reclose sequencer with a behavioural breaker.
// Assumes a 4-cycle millisecond tick so that times stay short.
`timescale 1ns/10ps
module testbench;
  import reclose_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, sl;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [2:0]  phase_pickup = 0;
  logic        general_pickup = 0, starter_trip = 0, any_trip = 0, cb_aux_closed;
  logic        ground_pickup = 0, ext_start_ground = 0, ext_start_phase = 0;
  logic        close_cmd, dyn_block, ground_program, irq;
  int          n_mismatch = 0, n_checks = 0, cycles = 0;

  // Clock and the cycle ceiling that cuts a hang short.
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  reclose_seq #(.TICK_DIV(4)) dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_pickup(phase_pickup), .ground_pickup(ground_pickup), .general_pickup(general_pickup),
    .starter_trip(starter_trip), .any_trip(any_trip), .ext_start_ground(ext_start_ground),
    .ext_start_phase(ext_start_phase),
    .cb_aux_closed(cb_aux_closed), .close_cmd(close_cmd), .dyn_block(dyn_block),
    .ground_program(ground_program), .irq(irq));
  breaker_model cb (.clk(clk), .arst_n(arst_n), .trip(any_trip), .close_cmd(close_cmd),
    .cb_aux_closed(cb_aux_closed));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer; read data and the error flag are taken at the access edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    sl = pslverr;
    q = prdata;
    psel <= 0; penable <= 0;
  endtask : apb

  // Waits, bounded, for close_cmd (0), dyn_block (1) or irq (2) to reach a level.
  task automatic wait_on(input int s, input logic lvl);
    int k;
    k = 0;
    while (((s == 0) ? close_cmd : (s == 1) ? dyn_block : irq) !== lvl && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    check(k < 2000, 1);
  endtask : wait_on

  // A fault picks up, trips, and clears two cycles after the breaker opened.
  task automatic fault(input logic [2:0] ph);
    int k;
    phase_pickup <= ph; general_pickup <= 1; ground_pickup <= 1;
    @(posedge clk);
    starter_trip <= 1; any_trip <= 1;
    for (k = 0; k < 100 && cb_aux_closed !== 1'b0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    phase_pickup <= 0; general_pickup <= 0; starter_trip <= 0; any_trip <= 0; ground_pickup <= 0;
  endtask : fault

  // External starts with no protection pickup select their own program.
  task automatic t_ext;
    for (int g = 0; g < 2; g++)
    begin
      ext_start_ground <= g[0]; ext_start_phase <= !g[0]; any_trip <= 1;
      repeat (2) @(posedge clk);
      ext_start_ground <= 0; ext_start_phase <= 0; any_trip <= 0;
      wait_on(0, 1);
      check(ground_program, g);
      repeat (30) @(posedge clk);
      apb(0, STATUS_ADDR, 0); check(q & 32'h0000_01E7, 0);
    end
    $display("test ext done");
  endtask : t_ext

  task automatic t_regs;
    apb(0, LIMITS_ADDR, 0); check(q, 32'h0000_0011);
    apb(0, RESTRAINT_ADDR, 0); check(q, 32'h0000_0064);
    apb(0, 8'h30, 0); check(sl, 1);
    foreach (q[i]) if (i < 4) apb(1, DEAD_GND_ADDR + 4 * i, 1 + i);
    for (int i = 0; i < 4; i++) apb(1, DEAD_PH_ADDR + 4 * i, 2);
    apb(1, RESTRAINT_ADDR, 3); apb(1, CLOSE_MAX_ADDR, 2); apb(1, BLOCK_T_ADDR, 3);
    apb(1, ACTION_T_ADDR, 5); apb(1, CTRL_ADDR, 3);
    $display("test regs done");
  endtask : t_regs

  task automatic t_ground;
    apb(1, IRQ_MASK_ADDR, 2);
    fault(3'h1);
    wait_on(0, 1);
    check(ground_program, 1);
    wait_on(0, 0);
    wait_on(2, 1);
    apb(0, IRQ_STAT_ADDR, 0); check(q, 32'h0000_0003);
    apb(0, STATUS_ADDR, 0); check(q & 32'h0000_01E7, 0);
    check(irq, 0);
    $display("test ground done");
  endtask : t_ground

  task automatic t_phase;
    apb(1, LIMITS_ADDR, 32'h0000_0051); apb(1, IRQ_MASK_ADDR, 4);
    fault(3'h3);
    for (int i = 0; i < 5; i++)
    begin
      wait_on(0, 1);
      check(ground_program, 0);
      fault(3'h3);
      check(close_cmd, 0);
    end
    wait_on(1, 1);
    check(irq, 1);
    apb(0, STATUS_ADDR, 0); check(q & 32'h0000_01E7, 32'h0000_00A7);
    wait_on(1, 0);
    apb(0, IRQ_STAT_ADDR, 0);
    $display("test phase done");
  endtask : t_phase

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence after reset.
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    t_regs();
    t_ground();
    t_phase();
    t_ext();
    report_and_stop();
  end
endmodule : testbench
